// *** bench/lb_masters.sv ***
// Behavioural local bus masters: request, own the bus, run one cycle
`timescale 1ns/10ps
module lb_masters (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Bench commands
	input wire logic [4:0] want_i,
	input wire logic [7:0] hold_i,
	input wire logic claim_i,
	input wire logic offb_i,
	// Block side
	input wire logic [4:0] gnt_i,
	input wire logic tea_i,
	output logic [4:0] req_o,
	output logic cyc_o,
	output logic off_o,
	output logic done_o
);
	logic [7:0] cnt;
	always @(posedge mclk_i) begin
		done_o <= 1'b0;
		req_o <= req_o | want_i;
		if (!rstn_i) begin
			req_o <= 5'h00;
			cyc_o <= 1'b0;
			off_o <= 1'b0;
		end else if (!cyc_o) begin
			if ((req_o & gnt_i) != 5'h00) begin
				cyc_o <= 1'b1;
				off_o <= offb_i;
				cnt <= hold_i;
			end
		end else if (tea_i || done_o) begin
			// Owner drops its request once its transfer is over
			req_o <= (req_o | want_i) & ~gnt_i;
			cyc_o <= 1'b0;
			off_o <= 1'b0;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end else if (claim_i || off_o) begin
			// An unclaimed on-board address is never acknowledged
			done_o <= 1'b1;
		end
	end
endmodule

// *** bench/lbr_asserts.sv ***
// Port-level checks of the local bus resource block
`timescale 1ns/10ps
module lbr_asserts #(
	parameter bit HAS_BACKPLANE = 1'b1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Bus cycle monitor and arbiter
	input wire logic lb_cycle_i,
	input wire logic lb_offboard_i,
	input wire logic lb_done_i,
	input wire logic transfer_error_ack_o,
	input wire logic [lbr_pkg::N_MASTER-1:0] arb_req_i,
	input wire logic [lbr_pkg::N_MASTER-1:0] arb_gnt_o,
	// Watchdog actions
	input wire logic sysreset_o,
	input wire logic local_reset_o,
	input wire logic board_fail_o
);
	import lbr_pkg::*;
	logic [11:0] lbt_cnt_ff, nxt_lbt_cnt;
	logic [4:0] sys_cnt_ff, nxt_sys_cnt;
	// Length of the running on-board unacknowledged cycle and of the system reset pulse
	always_comb begin
		nxt_lbt_cnt = (lb_cycle_i && !lb_done_i && !lb_offboard_i) ? lbt_cnt_ff + 12'h001 : 12'h000;
		nxt_sys_cnt = sysreset_o ? sys_cnt_ff + 5'h01 : 5'h00;
		if (!rstn_i) begin
			nxt_lbt_cnt = 12'h000;
			nxt_sys_cnt = 5'h00;
		end
	end
	always_ff @(posedge mclk_i) begin
		lbt_cnt_ff <= nxt_lbt_cnt;
		sys_cnt_ff <= nxt_sys_cnt;
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_loc8;
		local_reset_o [*8];
	endsequence
	property p_gnt_onehot; $onehot0(arb_gnt_o); endproperty
	a_gnt_onehot: assert property (p_gnt_onehot) else $error("more than one grant");
	property p_gnt_hold; (arb_gnt_o & arb_req_i) != 5'h00 |=> $stable(arb_gnt_o); endproperty
	a_gnt_hold: assert property (p_gnt_hold) else $error("grant moved while held");
	property p_gnt_prio;
		(arb_gnt_o & arb_req_i) == 5'h00 && arb_req_i != 5'h00
			|=> arb_gnt_o == ($past(arb_req_i) & (~$past(arb_req_i) + 5'h01));
	endproperty
	a_gnt_prio: assert property (p_gnt_prio) else $error("grant not highest priority");
	property p_tea_pulse; transfer_error_ack_o |=> !transfer_error_ack_o; endproperty
	a_tea_pulse: assert property (p_tea_pulse) else $error("error ack too long");
	property p_tea_cause; transfer_error_ack_o |-> lbt_cnt_ff >= 12'h050; endproperty
	a_tea_cause: assert property (p_tea_cause) else $error("error ack too early");
	property p_sys_len; $fell(sysreset_o) && $past(rstn_i) |-> sys_cnt_ff == 5'h10; endproperty
	a_sys_len: assert property (p_sys_len) else $error("system reset pulse length");
	property p_loc_len; $rose(local_reset_o) |-> s_loc8 ##1 s_loc8 ##1 !local_reset_o; endproperty
	a_loc_len: assert property (p_loc_len) else $error("local reset pulse length");
	property p_act_excl; $onehot0({sysreset_o, local_reset_o, board_fail_o}); endproperty
	a_act_excl: assert property (p_act_excl) else $error("two watchdog actions");
	property p_no_sys; HAS_BACKPLANE == 1'b0 |-> !sysreset_o; endproperty
	a_no_sys: assert property (p_no_sys) else $error("system reset without backplane");
endmodule
bind local_bus_res lbr_asserts #(.HAS_BACKPLANE(HAS_BACKPLANE)) chk (.mclk_i, .rstn_i,
	.lb_cycle_i, .lb_offboard_i, .lb_done_i, .transfer_error_ack_o, .arb_req_i, .arb_gnt_o,
	.sysreset_o, .local_reset_o, .board_fail_o);

// *** bench/local_bus_res_tb.sv ***
// Self-checking bench of the local bus resource block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %s expected %0h seen %0h", nm, e, g); end end
module local_bus_res_tb;
	import lbr_pkg::*;
	logic mclk, rstn, rd, wr, wreq, claim, offb, transfer_error_ack, cyc, off, done, sysr, locr, fail;
	logic [3:0] adr;
	logic [31:0] wdat, rdat, got, v;
	logic [4:0] want, req, gnt, m;
	logic [7:0] hold, swi;
	logic [5:0] tick;
	int err_total, checks, cyc_n, p, t0, n, lim;
	local_bus_res DUT (.mclk_i(mclk), .rstn_i(rstn), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .lb_cycle_i(cyc), .lb_offboard_i(off), .lb_done_i(done),
		.transfer_error_ack_o(transfer_error_ack), .arb_req_i(req), .arb_gnt_o(gnt), .tick_irq_o(tick),
		.swi_irq_o(swi), .sysreset_o(sysr), .local_reset_o(locr), .board_fail_o(fail));
	lb_masters pm (.mclk_i(mclk), .rstn_i(rstn), .want_i(want), .hold_i(hold), .claim_i(claim),
		.offb_i(offb), .gnt_i(gnt), .tea_i(transfer_error_ack), .req_o(req), .cyc_o(cyc), .off_o(off),
		.done_o(done));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) cyc_n <= cyc_n + 1;
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge mclk);
			k++;
		end while (wreq !== 1'b0 && k < 40);
		if (wreq !== 1'b0) err_total++;
		got = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic arb_round(input logic [4:0] f, input logic [4:0] r);
		logic [4:0] left, prev;
		n = 0;
		while (gnt !== 5'h00 && n < 300) begin @(posedge mclk); n++; end
		want <= f;
		@(posedge mclk);
		want <= 5'h00;
		while (gnt !== f && n < 300) begin @(posedge mclk); n++; end
		`CHK("first grant", f, gnt)
		want <= r;
		@(posedge mclk);
		want <= 5'h00;
		left = r & ~f;
		prev = f;
		while (left != 5'h00 && n < 2000) begin
			@(posedge mclk);
			n++;
			if (gnt !== prev && gnt !== 5'h00) begin
				`CHK("grant order", left & (~left + 5'h01), gnt)
				left = left & ~gnt;
				prev = gnt;
			end
		end
		`CHK("grants left", 5'h00, left)
	endtask
	initial begin
		#(100 * 40000);
		err_total++;
		wrap_up();
	end
	initial begin
		{rstn, rd, wr, claim, offb, adr, wdat, want, hold} = '0;
		{err_total, checks, cyc_n} = '0;
		void'($urandom(32'hA96C));
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		bus(0, REG_WD_PERIOD, 0);
		`CHK("wd period reset", WD_PERIOD_RESET, got)
		bus(1, 4'hF, 32'hFFFFFFFF);
		bus(0, 4'hF, 0);
		`CHK("unmapped", 32'h00000000, got)
		$display("registers done");
		for (int i = 0; i < 9; i++) begin
			v = (i < 8) ? 32'h1 << i : $urandom;
			bus(1, REG_SWI, v);
			`CHK("soft irq", v[7:0], swi)
		end
		$display("soft interrupts done");
		for (int i = 0; i < 6; i++) begin
			p = 2 + $urandom % 3;
			bus(1, REG_TICK_BASE + 4'(i), 32'(p));
			bus(1, REG_TICK_EN, 32'h1 << i);
			for (int k = 0; k < 3; k++) begin
				n = 0;
				while (tick[i] !== 1'b1 && n < 100) begin @(posedge mclk); n++; end
				if (k > 0) `CHK("tick period", p * CYC_PER_US, cyc_n - t0)
				t0 = cyc_n;
				bus(1, REG_STATUS, 32'h1 << i);
			end
			bus(1, REG_TICK_EN, 0);
		end
		$display("tick timers done");
		bus(1, REG_WD_PERIOD, 32'h3);
		for (int a = 0; a < 3; a++) begin
			bus(1, REG_CTRL, 32'h8 | (32'(a) << 4));
			repeat (6) begin
				repeat (12) @(posedge mclk);
				bus(1, REG_WD_KICK, 0);
			end
			bus(0, REG_STATUS, 0);
			`CHK("wd kept alive", 1'b0, got[STAT_WD])
			n = 0;
			while ({sysr, locr, fail} === 3'b000 && n < 60) begin @(posedge mclk); n++; end
			`CHK("wd action", (a == 0) ? 3'b010 : (a == 1) ? 3'b001 : 3'b100, {sysr, locr, fail})
			`CHK("wd delay", 1'b1, n >= 18 && n <= 42)
			bus(0, REG_STATUS, 0);
			`CHK("wd flag", 1'b1, got[STAT_WD])
			bus(1, REG_CTRL, 0);
			bus(1, REG_STATUS, 32'h100);
			repeat (16) @(posedge mclk);
		end
		$display("watchdog done");
		hold <= 8'hFF;
		for (int k = 0; k < 6; k++) begin
			lim = CYC_PER_US * ((k == 0) ? LBT_8_US : (k == 1) ? LBT_64_US :
				(k == 2) ? LBT_256_US : 0);
			bus(1, REG_CTRL, (k == 5) ? 32'h0 : (k == 4) ? 32'h1 : 32'h1 | (32'(k) << 1));
			offb <= (k == 4);
			claim <= 1'b0;
			want <= 5'h10;
			@(posedge mclk);
			want <= 5'h00;
			n = 0;
			while (transfer_error_ack !== 1'b1 && n < 3000) begin @(posedge mclk); n++; end
			if (lim > 0) `CHK("timeout span", 1'b1, n >= lim - 2 && n <= lim + 16)
			else `CHK("no timeout", 3000, n)
			bus(0, REG_STATUS, 0);
			`CHK("timeout flag", lim > 0, got[STAT_LBT])
			claim <= 1'b1;
			n = 0;
			while (cyc !== 1'b0 && n < 300) begin @(posedge mclk); n++; end
			`CHK("cycle ended", 1'b0, cyc)
			bus(1, REG_STATUS, 32'h200);
		end
		bus(1, REG_CTRL, 0);
		$display("bus timer done");
		for (int r = 0; r < 5; r++) begin
			v = (r == 0) ? 32'h10 : 32'h1 << ($urandom % 5);
			m = (r == 0) ? 5'h0F : 5'($urandom);
			hold <= 8'($urandom % 6);
			arb_round(v[4:0], m);
		end
		$display("arbiter done");
		wrap_up();
	end
endmodule

// *** logic/bus_arbiter.sv ***
// Fixed-priority local bus arbiter, index 0 highest
`timescale 1ns/10ps
module bus_arbiter (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Requests and grants
	input wire logic [4:0] req_i,
	output logic [4:0] gnt_o
);
	logic [4:0] gnt_ff;
	logic [4:0] nxt_gnt;

	function automatic logic [4:0] pick(input logic [4:0] r);
		logic [4:0] g;
		g = 5'h00;
		for (int i = 4; i >= 0; i--) begin
			if (r[i]) begin
				g = 5'h00;
				g[i] = 1'b1;
			end
		end
		return g;
	endfunction

	always_comb begin
		nxt_gnt = gnt_ff;
		if ((gnt_ff & req_i) == 5'h00) begin
			nxt_gnt = pick(req_i);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			gnt_ff <= 5'h00;
		end else begin
			gnt_ff <= nxt_gnt;
		end
	end

	assign gnt_o = gnt_ff;
endmodule

// *** logic/lbr_pkg.sv ***
// Constants, register map and types shared by the local bus resource block
package lbr_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned US_PER_S = 1_000_000;
	localparam int unsigned CYC_PER_US = (CLK_HZ + US_PER_S - 1) / US_PER_S;
	localparam logic [3:0] PRESC_LAST = 4'(CYC_PER_US - 1);

	localparam int unsigned N_TICK = 6;
	localparam int unsigned N_SWI = 8;
	localparam int unsigned N_MASTER = 5;

	// Register word indices on the Avalon slave (byte address is four times the index)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_WD_PERIOD = 4'h2;
	localparam logic [3:0] REG_WD_KICK = 4'h3;
	localparam logic [3:0] REG_SWI = 4'h4;
	localparam logic [3:0] REG_TICK_EN = 4'h5;
	localparam logic [3:0] REG_ARB_GNT = 4'h6;
	localparam logic [3:0] REG_TICK_BASE = 4'h8;

	// Control register fields
	localparam int unsigned CTRL_LBT_EN = 0;
	localparam int unsigned CTRL_LBT_SEL = 1;
	localparam int unsigned CTRL_WD_EN = 3;
	localparam int unsigned CTRL_WD_ACT = 4;
	localparam logic [5:0] CTRL_RESET = 6'h00;

	// Status register fields
	localparam int unsigned STAT_TICK = 0;
	localparam int unsigned STAT_WD = 8;
	localparam int unsigned STAT_LBT = 9;

	localparam logic [31:0] WD_PERIOD_RESET = 32'h000F4240;
	localparam logic [31:0] TICK_PERIOD_RESET = 32'h00000000;

	// Local bus timeout limits in microseconds
	localparam int unsigned LBT_8_US = 8;
	localparam int unsigned LBT_64_US = 64;
	localparam int unsigned LBT_256_US = 256;

	// Length of a watchdog reset pulse
	localparam int unsigned WD_RST_CYC = 16;

	typedef enum logic [1:0] {
		LBT_LIM_8 = 2'b00,
		LBT_LIM_64 = 2'b01,
		LBT_LIM_256 = 2'b10,
		LBT_LIM_INF = 2'b11
	} lbt_sel_t;

	typedef enum logic [1:0] {
		WD_ACT_LOCAL = 2'b00,
		WD_ACT_FAIL = 2'b01,
		WD_ACT_SYS = 2'b10,
		WD_ACT_NONE = 2'b11
	} wd_act_t;

	typedef enum logic [1:0] {
		LBT_IDLE = 2'b00,
		LBT_RUN = 2'b01,
		LBT_ERR = 2'b10,
		LBT_WAIT = 2'b11
	} lbt_state_t;
endpackage

// *** logic/local_bus_res.sv ***
// Local bus support resources: tick timers, watchdog, soft interrupts, bus timeout, arbiter
// Contract
// - Six independent 32-bit tick timers counting in one microsecond steps.
// - Each tick timer raises its interrupt repeatedly at the programmed period.
// - Enabled watchdog times out unless software restarts it within the interval.
// - Watchdog timeout drives the selected system reset, local reset or fail.
// - Only the backplane-side build can drive the system reset action.
// - Eight software-set interrupt lines give real hardware interrupt requests.
// - Enabled bus timer ends an overlong access with a transfer error acknowledge.
// - Bus timeout limit selectable: 8, 64, 256 microseconds or none.
// - The bus timer does not run for backplane-bound cycles.
// - Only the backplane-side build recognises offboard accesses.
// - Fixed priority: network, module DMA, SCSI, backplane slave, processor.
// - Unclaimed addresses end by bus timeout, so software must enable it.
`timescale 1ns/10ps
module local_bus_res #(
	parameter bit HAS_BACKPLANE = 1'b1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Local bus cycle monitor
	input wire logic lb_cycle_i,
	input wire logic lb_offboard_i,
	input wire logic lb_done_i,
	output logic transfer_error_ack_o,
	// Arbitration
	input wire logic [lbr_pkg::N_MASTER-1:0] arb_req_i,
	output logic [lbr_pkg::N_MASTER-1:0] arb_gnt_o,
	// Interrupt requests
	output logic [lbr_pkg::N_TICK-1:0] tick_irq_o,
	output logic [lbr_pkg::N_SWI-1:0] swi_irq_o,
	// Watchdog actions
	output logic sysreset_o,
	output logic local_reset_o,
	output logic board_fail_o
);
	import lbr_pkg::*;

	localparam logic [4:0] RST_LAST = 5'(WD_RST_CYC - 1);

	function automatic logic [8:0] lbt_limit(input logic [1:0] sel);
		case (sel)
			LBT_LIM_8: return 9'(LBT_8_US);
			LBT_LIM_64: return 9'(LBT_64_US);
			default: return 9'(LBT_256_US);
		endcase
	endfunction

	// Microsecond prescaler
	logic [3:0] presc_ff;
	logic [3:0] nxt_presc;
	logic us_tick;

	always_comb begin
		nxt_presc = (presc_ff == PRESC_LAST) ? 4'h0 : presc_ff + 4'h1;
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			presc_ff <= 4'h0;
		end else begin
			presc_ff <= nxt_presc;
		end
	end

	assign us_tick = (presc_ff == PRESC_LAST);

	// Avalon handshake: one wait state, then read data and write strobe
	logic ack_ff;
	logic nxt_ack;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic wr_en;
	logic access;

	assign access = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = access & ~ack_ff;
	assign wr_en = avs_write_i & ack_ff;
	assign avs_readdata_o = rdata_ff;

	// Software state
	logic [5:0] ctrl_ff;
	logic [5:0] nxt_ctrl;
	logic [31:0] wd_period_ff;
	logic [31:0] nxt_wd_period;
	logic [N_SWI-1:0] swi_ff;
	logic [N_SWI-1:0] nxt_swi;
	logic [N_TICK-1:0] tick_en_ff;
	logic [N_TICK-1:0] nxt_tick_en;
	logic [31:0] tick_period_ff [N_TICK];
	logic [31:0] nxt_tick_period [N_TICK];
	logic [N_TICK-1:0] tick_flag_ff;
	logic [N_TICK-1:0] nxt_tick_flag;
	logic wd_flag_ff;
	logic nxt_wd_flag;
	logic lbt_flag_ff;
	logic nxt_lbt_flag;
	logic [N_TICK-1:0] tick_exp;
	logic wd_kick;
	logic wd_expire;
	logic lbt_fire;
	logic [31:0] stat_clr;

	assign wd_kick = wr_en && avs_address_i == REG_WD_KICK;
	assign stat_clr = (wr_en && avs_address_i == REG_STATUS) ? avs_writedata_i : 32'h00000000;

	function automatic logic [31:0] read_mux(input logic [3:0] a);
		logic [31:0] d;
		d = 32'h00000000;
		if (a == REG_CTRL) begin
			d[5:0] = ctrl_ff;
		end else if (a == REG_STATUS) begin
			d[STAT_TICK +: N_TICK] = tick_flag_ff;
			d[STAT_WD] = wd_flag_ff;
			d[STAT_LBT] = lbt_flag_ff;
		end else if (a == REG_WD_PERIOD) begin
			d = wd_period_ff;
		end else if (a == REG_SWI) begin
			d[N_SWI-1:0] = swi_ff;
		end else if (a == REG_TICK_EN) begin
			d[N_TICK-1:0] = tick_en_ff;
		end else if (a == REG_ARB_GNT) begin
			d[N_MASTER-1:0] = arb_gnt_o;
		end else if (a >= REG_TICK_BASE && a < REG_TICK_BASE + 4'(N_TICK)) begin
			d = tick_period_ff[3'(a - REG_TICK_BASE)];
		end
		return d;
	endfunction

	always_comb begin
		nxt_ack = access & ~ack_ff;
		nxt_rdata = rdata_ff;
		if (avs_read_i && !ack_ff) begin
			nxt_rdata = read_mux(avs_address_i);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
		end else begin
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end

	// Register writes; hardware set wins over software clear
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_wd_period = wd_period_ff;
		nxt_swi = swi_ff;
		nxt_tick_en = tick_en_ff;
		for (int i = 0; i < N_TICK; i++) begin
			nxt_tick_period[i] = tick_period_ff[i];
		end
		if (wr_en) begin
			if (avs_address_i == REG_CTRL) begin
				nxt_ctrl = avs_writedata_i[5:0];
			end else if (avs_address_i == REG_WD_PERIOD) begin
				nxt_wd_period = avs_writedata_i;
			end else if (avs_address_i == REG_SWI) begin
				nxt_swi = avs_writedata_i[N_SWI-1:0];
			end else if (avs_address_i == REG_TICK_EN) begin
				nxt_tick_en = avs_writedata_i[N_TICK-1:0];
			end else if (avs_address_i >= REG_TICK_BASE &&
					avs_address_i < REG_TICK_BASE + 4'(N_TICK)) begin
				nxt_tick_period[3'(avs_address_i - REG_TICK_BASE)] = avs_writedata_i;
			end
		end
		nxt_tick_flag = (tick_flag_ff & ~stat_clr[STAT_TICK +: N_TICK]) | tick_exp;
		nxt_wd_flag = (wd_flag_ff & ~stat_clr[STAT_WD]) | wd_expire;
		nxt_lbt_flag = (lbt_flag_ff & ~stat_clr[STAT_LBT]) | lbt_fire;
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			ctrl_ff <= CTRL_RESET;
			wd_period_ff <= WD_PERIOD_RESET;
			swi_ff <= '0;
			tick_en_ff <= '0;
			for (int i = 0; i < N_TICK; i++) begin
				tick_period_ff[i] <= TICK_PERIOD_RESET;
			end
			tick_flag_ff <= '0;
			wd_flag_ff <= 1'b0;
			lbt_flag_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			wd_period_ff <= nxt_wd_period;
			swi_ff <= nxt_swi;
			tick_en_ff <= nxt_tick_en;
			for (int i = 0; i < N_TICK; i++) begin
				tick_period_ff[i] <= nxt_tick_period[i];
			end
			tick_flag_ff <= nxt_tick_flag;
			wd_flag_ff <= nxt_wd_flag;
			lbt_flag_ff <= nxt_lbt_flag;
		end
	end

	assign swi_irq_o = swi_ff;
	assign tick_irq_o = tick_flag_ff;

	// Tick timers
	tick_if tif [N_TICK] ();

	for (genvar g = 0; g < N_TICK; g++) begin : g_tick
		assign tif[g].en = tick_en_ff[g];
		assign tif[g].period = tick_period_ff[g];
		assign tick_exp[g] = tif[g].expire;
		tick_timer u_tick (
			.mclk_i(mclk_i),
			.rstn_i(rstn_i),
			.us_tick_i(us_tick),
			.tif(tif[g])
		);
	end

	// Watchdog
	logic wd_en;
	logic [1:0] wd_act;
	logic [31:0] wd_cnt_ff;
	logic [31:0] nxt_wd_cnt;
	logic wd_exp_ff;
	logic nxt_wd_exp;
	logic [4:0] rst_cnt_ff;
	logic [4:0] nxt_rst_cnt;
	logic rst_act_ff;
	logic nxt_rst_act;
	logic rst_sys_ff;
	logic nxt_rst_sys;

	assign wd_en = ctrl_ff[CTRL_WD_EN];
	assign wd_act = ctrl_ff[CTRL_WD_ACT +: 2];
	assign wd_expire = wd_exp_ff;

	always_comb begin
		nxt_wd_cnt = wd_cnt_ff;
		nxt_wd_exp = 1'b0;
		if (!wd_en || wd_kick) begin
			nxt_wd_cnt = 32'h00000000;
		end else if (us_tick && !wd_flag_ff) begin
			if (wd_cnt_ff >= wd_period_ff - 32'h00000001) begin
				nxt_wd_exp = 1'b1;
				nxt_wd_cnt = 32'h00000000;
			end else begin
				nxt_wd_cnt = wd_cnt_ff + 32'h00000001;
			end
		end
	end

	// Reset pulse; system reset falls back to local reset without a backplane
	always_comb begin
		nxt_rst_cnt = rst_cnt_ff;
		nxt_rst_act = rst_act_ff;
		nxt_rst_sys = rst_sys_ff;
		if (wd_exp_ff && (wd_act == WD_ACT_LOCAL || wd_act == WD_ACT_SYS)) begin
			nxt_rst_act = 1'b1;
			nxt_rst_cnt = 5'h00;
			nxt_rst_sys = (wd_act == WD_ACT_SYS) && HAS_BACKPLANE;
		end else if (rst_act_ff) begin
			if (rst_cnt_ff == RST_LAST) begin
				nxt_rst_act = 1'b0;
				nxt_rst_sys = 1'b0;
			end else begin
				nxt_rst_cnt = rst_cnt_ff + 5'h01;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			wd_cnt_ff <= 32'h00000000;
			wd_exp_ff <= 1'b0;
			rst_cnt_ff <= 5'h00;
			rst_act_ff <= 1'b0;
			rst_sys_ff <= 1'b0;
		end else begin
			wd_cnt_ff <= nxt_wd_cnt;
			wd_exp_ff <= nxt_wd_exp;
			rst_cnt_ff <= nxt_rst_cnt;
			rst_act_ff <= nxt_rst_act;
			rst_sys_ff <= nxt_rst_sys;
		end
	end

	assign sysreset_o = rst_act_ff & rst_sys_ff;
	assign local_reset_o = rst_act_ff & ~rst_sys_ff;
	assign board_fail_o = wd_flag_ff & (wd_act == WD_ACT_FAIL);

	// Local bus access timer
	lbt_state_t lbt_st_ff;
	lbt_state_t nxt_lbt_st;
	logic [8:0] lbt_cnt_ff;
	logic [8:0] nxt_lbt_cnt;
	logic lbt_arm;
	logic offboard;

	// Only the backplane-side build can see offboard cycles
	assign offboard = HAS_BACKPLANE & lb_offboard_i;
	assign lbt_arm = ctrl_ff[CTRL_LBT_EN] &&
		ctrl_ff[CTRL_LBT_SEL +: 2] != LBT_LIM_INF && !offboard;

	always_comb begin
		nxt_lbt_st = lbt_st_ff;
		nxt_lbt_cnt = lbt_cnt_ff;
		case (lbt_st_ff)
			LBT_IDLE: begin
				nxt_lbt_cnt = 9'h000;
				if (lb_cycle_i && !lb_done_i && lbt_arm) begin
					nxt_lbt_st = LBT_RUN;
				end
			end
			LBT_RUN: begin
				if (lb_done_i || !lb_cycle_i || !lbt_arm) begin
					nxt_lbt_st = LBT_IDLE;
				end else if (us_tick) begin
					if (lbt_cnt_ff >= lbt_limit(ctrl_ff[CTRL_LBT_SEL +: 2])) begin
						nxt_lbt_st = LBT_ERR;
					end else begin
						nxt_lbt_cnt = lbt_cnt_ff + 9'h001;
					end
				end
			end
			LBT_ERR: begin
				nxt_lbt_st = LBT_WAIT;
			end
			default: begin
				if (!lb_cycle_i) begin
					nxt_lbt_st = LBT_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			lbt_st_ff <= LBT_IDLE;
			lbt_cnt_ff <= 9'h000;
		end else begin
			lbt_st_ff <= nxt_lbt_st;
			lbt_cnt_ff <= nxt_lbt_cnt;
		end
	end

	assign lbt_fire = (lbt_st_ff == LBT_ERR);
	assign transfer_error_ack_o = lbt_fire;

	// Arbiter
	bus_arbiter u_arb (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.req_i(arb_req_i),
		.gnt_o(arb_gnt_o)
	);
endmodule

// *** logic/tick_if.sv ***
// Control and event signals between the register file and one tick timer
`timescale 1ns/10ps
interface tick_if;
	logic en;
	logic [31:0] period;
	logic expire;
	modport ctrl (output en, output period, input expire);
	modport timer (input en, input period, output expire);
endinterface

// *** logic/tick_timer.sv ***
// One 32-bit periodic tick timer counting microsecond strobes
`timescale 1ns/10ps
module tick_timer (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Microsecond strobe
	input wire logic us_tick_i,
	// Control from the register file
	tick_if.timer tif
);
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic exp_ff;
	logic nxt_exp;

	// Period zero leaves the timer parked
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_exp = 1'b0;
		if (!tif.en || tif.period == 32'h00000000) begin
			nxt_cnt = 32'h00000000;
		end else if (us_tick_i) begin
			if (cnt_ff >= tif.period - 32'h00000001) begin
				nxt_cnt = 32'h00000000;
				nxt_exp = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 32'h00000001;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			cnt_ff <= 32'h00000000;
			exp_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			exp_ff <= nxt_exp;
		end
	end

	assign tif.expire = exp_ff;
endmodule
